/* hdl/imp_exec.sv */
// executor for the indexed move and the literal push instructions
`timescale 1ns/100ps
`default_nettype none
`include "imp_cfg.svh"

module imp_exec (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	input  wire logic                   i_instr_valid,
	input  wire logic [`IMP_WORD_W-1:0] i_instr,
	output logic                        o_instr_ready,
	input  wire logic                   i_fp_load,
	input  wire logic [`IMP_ADDR_W-1:0] i_fp_value,
	output logic [`IMP_ADDR_W-1:0]      o_fp,
	output logic [`IMP_ADDR_W-1:0]      o_mem_addr,
	output logic                        o_mem_rd,
	output logic                        o_mem_wr,
	output logic [`IMP_DATA_W-1:0]      o_mem_wdata,
	input  wire logic [`IMP_DATA_W-1:0] i_mem_rdata,
	output logic                        o_busy,
	output logic                        o_done,
	output logic                        o_nop
);

	imp_pkg::imp_regs_t r_q;
	imp_pkg::imp_regs_t r_d;

	logic                   take;
	logic                   is_move;
	logic                   is_move2;
	logic                   is_push;
	logic [`IMP_OFS_W-1:0]  ofs;
	logic [`IMP_DATA_W-1:0] lit;
	logic [`IMP_ADDR_W-1:0] ix_addr;
	logic                   ix_ind;

	// handshake and decode of the offered word
	assign take     = i_instr_valid & r_q.ready;
	assign is_move  = (i_instr & `IMP_MOVE_MASK) == `IMP_MOVE_CODE;
	assign is_move2 = (i_instr & `IMP_MOVE2_MASK) == `IMP_MOVE2_CODE;
	assign is_push  = (i_instr & `IMP_PUSH_MASK) == `IMP_PUSH_CODE;
	assign ofs      = i_instr[`IMP_OFS_LSB +: `IMP_OFS_W];
	assign lit      = i_instr[`IMP_LIT_LSB +: `IMP_DATA_W];

	// indexed address, wraps in the 12-bit space
	assign ix_addr = r_q.fp + {{(`IMP_ADDR_W-`IMP_OFS_W){1'b0}}, ofs}; // [RL1] [RL2]

	// indirect register window
	assign ix_ind = (ix_addr >= `IMP_IND_LO) && (ix_addr <= `IMP_IND_HI);

	always_comb begin
		r_d          = r_q;
		r_d.mem.rd   = 1'b0;
		r_d.mem.wr   = 1'b0;
		r_d.done     = 1'b0;
		r_d.nop      = 1'b0;
		case (r_q.state)
			imp_pkg::IMP_IDLE: begin
				if (take && is_move) begin
					// first move word: source address
					r_d.mem.addr = ix_addr; // [RL1]
					r_d.mem.rd   = ~ix_ind; // [RL4]
					r_d.src_ind  = ix_ind;
					r_d.state    = imp_pkg::IMP_RD; // [RL8]
					r_d.ready    = 1'b0;
				end else if (take && is_push) begin
					// single word push at the frame pointer
					r_d.mem.addr  = r_q.fp; // [RL6]
					r_d.mem.wr    = 1'b1; // [RL6]
					r_d.mem.wdata = lit; // [RL6]
					r_d.fp        = r_q.fp - `IMP_FP_STEP; // [RL7]
					r_d.done      = 1'b1; // [RL8]
				end
			end
			imp_pkg::IMP_RD: begin
				// memory answers one cycle after the read strobe
				r_d.state = imp_pkg::IMP_CAP;
			end
			imp_pkg::IMP_CAP: begin
				if (r_q.src_ind) begin
					r_d.data = `IMP_ZERO_DATA; // [RL4]
				end else begin
					r_d.data = i_mem_rdata;
				end
				r_d.state = imp_pkg::IMP_DST;
				r_d.ready = 1'b1;
			end
			imp_pkg::IMP_DST: begin
				if (take && is_move2) begin
					// second move word: destination address
					r_d.mem.addr  = ix_addr; // [RL1] [RL2]
					r_d.mem.wdata = r_q.data;
					r_d.mem.wr    = ~ix_ind; // [RL5]
					r_d.nop       = ix_ind; // [RL5]
					r_d.done      = 1'b1; // [RL8]
					r_d.state     = imp_pkg::IMP_IDLE;
					r_d.ready     = 1'b1;
				end
			end
			default: begin
				r_d.state = imp_pkg::IMP_IDLE;
				r_d.ready = 1'b1;
			end
		endcase
		// a core load of the pointer overrides the push decrement
		if (i_fp_load) begin
			r_d.fp = i_fp_value;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			r_q.state     <= imp_pkg::IMP_IDLE;
			r_q.fp        <= `IMP_FP_RESET;
			r_q.mem.addr  <= '0;
			r_q.mem.rd    <= 1'b0;
			r_q.mem.wr    <= 1'b0;
			r_q.mem.wdata <= '0;
			r_q.src_ind   <= 1'b0;
			r_q.data      <= '0;
			r_q.ready     <= 1'b1;
			r_q.done      <= 1'b0;
			r_q.nop       <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register
	assign o_instr_ready = r_q.ready;
	assign o_fp          = r_q.fp;
	assign o_mem_addr    = r_q.mem.addr;
	assign o_mem_rd      = r_q.mem.rd;
	assign o_mem_wr      = r_q.mem.wr;
	assign o_mem_wdata   = r_q.mem.wdata;
	assign o_busy        = ~r_q.state[0];
	assign o_done        = r_q.done;
	assign o_nop         = r_q.nop;

endmodule // imp_exec

`default_nettype wire

/* hdl/imp_cfg.svh */
// constants for the indexed move and literal push executor
//
// Behaviour
// RL1: move source and destination are frame pointer plus separate 7-bit offsets.
// RL2: both move addresses wrap within the full 12-bit, 4096-byte data space.
// RL3: software never names pc_low_byte or return_top bytes as move destination.
// RL4: move source hitting an indirect register yields data 00h, no access.
// RL5: move destination hitting an indirect register writes nothing, acts as no-op.
// RL6: push writes its 8-bit literal at the current frame pointer address.
// RL7: after the push write the frame pointer decrements by one.
// RL8: move is two words and two cycles, push one word; no status flags. Here a move takes four cycles (IDLE, RD, CAP, DST).
`ifndef IMP_CFG_SVH
`define IMP_CFG_SVH

`define IMP_ADDR_W        12
`define IMP_DATA_W        8
`define IMP_WORD_W        16
`define IMP_OFS_W         7

`define IMP_MOVE_MASK     16'hFF80
`define IMP_MOVE_CODE     16'hEB80
`define IMP_MOVE2_MASK    16'hF000
`define IMP_MOVE2_CODE    16'hF000
`define IMP_PUSH_MASK     16'hFF00
`define IMP_PUSH_CODE     16'hFA00

`define IMP_OFS_LSB       0
`define IMP_LIT_LSB       0

`define IMP_IND_LO        12'hFE0
`define IMP_IND_HI        12'hFEF

`define IMP_FP_RESET      12'h000
`define IMP_ZERO_DATA     8'h00
`define IMP_FP_STEP       12'h001

`endif

/* hdl/imp_pkg.sv */
// types for the indexed move and literal push executor
`include "imp_cfg.svh"

package imp_pkg;

	typedef enum logic [3:0] {
		IMP_IDLE  = 4'b0001,
		IMP_RD    = 4'b0010,
		IMP_CAP   = 4'b0100,
		IMP_DST   = 4'b1000
	} imp_state_t;

	typedef struct packed {
		logic [`IMP_ADDR_W-1:0] addr;
		logic                   rd;
		logic                   wr;
		logic [`IMP_DATA_W-1:0] wdata;
	} imp_mem_req_t;

	typedef struct packed {
		imp_state_t             state;
		logic [`IMP_ADDR_W-1:0] fp;
		imp_mem_req_t           mem;
		logic                   src_ind;
		logic [`IMP_DATA_W-1:0] data;
		logic                   ready;
		logic                   done;
		logic                   nop;
	} imp_regs_t;

endpackage : imp_pkg

/* bench/imp_exec_assertions.sv */
// assertions for the indexed move and literal push executor
`timescale 1ns/100ps
`default_nettype none
`include "imp_cfg.svh"
module imp_exec_assertions (
	input wire logic                   i_clk, i_reset, i_instr_valid, o_instr_ready, i_fp_load,
	input wire logic                   o_busy, o_mem_rd, o_mem_wr, o_done, o_nop,
	input wire logic [`IMP_WORD_W-1:0] i_instr,
	input wire logic [`IMP_ADDR_W-1:0] o_fp, o_mem_addr,
	input wire logic [`IMP_DATA_W-1:0] o_mem_wdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic                   tk, pu, m1, m2, ei;
	logic [`IMP_ADDR_W-1:0] ea;
	assign tk = i_instr_valid && o_instr_ready;
	assign pu = tk && !o_busy && (i_instr & `IMP_PUSH_MASK) == `IMP_PUSH_CODE;
	assign m1 = tk && !o_busy && (i_instr & `IMP_MOVE_MASK) == `IMP_MOVE_CODE;
	assign m2 = tk && o_busy && i_instr[15:12] == 4'hF;
	assign ea = o_fp + i_instr[6:0];
	assign ei = ea >= `IMP_IND_LO && ea <= `IMP_IND_HI;
	sequence s_gap;
		!o_instr_ready [*2] ##1 o_instr_ready;
	endsequence
	a_push_write: assert property (pu |=> o_mem_wr && o_mem_addr == $past(o_fp) && o_mem_wdata == $past(i_instr[7:0]))
		else $error("push write");
	a_push_dec: assert property (pu && !i_fp_load |=> o_fp == $past(o_fp) - `IMP_FP_STEP)
		else $error("push fp");
	a_push_one: assert property (pu |=> o_done && o_instr_ready && !o_busy)
		else $error("push length");
	a_move_gap: assert property (m1 |=> s_gap)
		else $error("move gap");
	a_src_read: assert property (m1 |=> o_mem_rd == !$past(ei) && (!o_mem_rd || o_mem_addr == $past(ea)))
		else $error("move read");
	a_dst_write: assert property (m2 |=> o_done && o_nop == $past(ei) && (o_nop || o_mem_addr == $past(ea)))
		else $error("move write");
	a_nop_nowr: assert property (o_nop |-> !o_mem_wr && o_done)
		else $error("nop wrote");
endmodule // imp_exec_assertions
bind imp_exec imp_exec_assertions i_chk (.*);
`default_nettype wire

/* bench/imp_exec_test.sv */
// self-checking bench for the indexed move and literal push executor
`timescale 1ns/100ps
`default_nettype none
`include "imp_cfg.svh"
module imp_exec_test;
	logic        i_clk = 1'h0, i_reset = 1'h1, i_instr_valid = 1'h0, i_fp_load = 1'h0;
	logic [15:0] i_instr = 16'h0;
	logic [11:0] i_fp_value = 12'h0, o_fp, o_mem_addr;
	logic [7:0]  i_mem_rdata = 8'h0, o_mem_wdata;
	logic        o_instr_ready, o_mem_rd, o_mem_wr, o_busy, o_done, o_nop;
	int          mismatches = 0, n_compared = 0;
	imp_exec i_dut (.*);
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) i_mem_rdata <= ~o_mem_addr[7:0];
	task automatic ck(input string nm, input logic [11:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic sendw(input logic [15:0] w);
		i_instr_valid <= 1'h1;
		i_instr <= w;
		@(posedge i_clk);
		while (o_instr_ready !== 1'h1) @(posedge i_clk);
		i_instr_valid <= 1'h0;
	endtask
	task automatic ldfp(input logic [11:0] f);
		@(posedge i_clk) i_fp_load <= 1'h1;
		i_fp_value <= f;
		@(posedge i_clk) i_fp_load <= 1'h0;
	endtask
	task automatic push_at(input logic [11:0] f, input logic [7:0] k);
		ldfp(f);
		sendw({8'hFA, k});
		#1 ck("push addr", o_mem_addr, f);
		ck("push data", o_mem_wdata, k);
		ck("push done", {o_mem_wr, o_done}, 2'h3);
		ck("push fp", o_fp, f - 12'h1);
	endtask
	task automatic move(input logic [11:0] f, input logic [6:0] s, d);
		logic [11:0] sa = f + s;
		logic [11:0] da = f + d;
		logic        si = sa >= `IMP_IND_LO && sa <= `IMP_IND_HI;
		logic        di = da >= `IMP_IND_LO && da <= `IMP_IND_HI;
		ldfp(f);
		sendw({9'h1D7, s});
		#1 ck("src rd", o_mem_rd, !si);
		if (!si) ck("src addr", o_mem_addr, sa);
		ck("move busy", {o_busy, o_instr_ready}, 2'h2);
		@(posedge i_clk);
		sendw({9'h1E0, d});
		#1 ck("dst kind", {o_mem_wr, o_nop, o_done}, {!di, di, 1'h1});
		if (!di) ck("dst addr", o_mem_addr, da);
		if (!di) ck("dst data", o_mem_wdata, si ? 12'h0 : {4'h0, ~sa[7:0]});
		ck("move end", {o_busy, o_instr_ready}, 2'h1);
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_reset <= 1'h0;
		@(posedge i_clk);
		#1 ck("reset fp", o_fp, `IMP_FP_RESET);
		ck("reset idle", {o_instr_ready, o_busy, o_mem_wr, o_mem_rd, o_done, o_nop}, 6'h20);
		push_at(12'h000, 8'hFF);
		push_at(12'h1EC, 8'h08);
		move(12'hFFA, 7'h05, 7'h7F);
		move(12'hFE0, 7'h00, 7'h40);
		move(12'hF80, 7'h5F, 7'h6F);
		end_of_test;
	end
	initial begin
		#20000;
		mismatches++;
		end_of_test;
	end
endmodule // imp_exec_test
`default_nettype wire
